/* hdl/ictc_regs.svh */
`ifndef ICTC_REGS_SVH
`define ICTC_REGS_SVH

// i/o space offsets of the control registers
`define ICTC_IO_GCTRL 16'h0000
`define ICTC_IO_FAR_LO 16'h0001
`define ICTC_IO_FAR_HI 16'h0002

// global control fields and values
`define ICTC_GCTRL_FLUSH_BIT 12
`define ICTC_GCTRL_RST 16'h0000
`define ICTC_FAR_RST 16'h0000
`define ICTC_CMD_INIT 16'hce3c
`define ICTC_CMD_FLUSH 16'hde3c

// fetch address fields
`define ICTC_TAG_HI 23
`define ICTC_TAG_LO 13
`define ICTC_IDX_HI 12
`define ICTC_IDX_LO 4
`define ICTC_WRD_HI 3
`define ICTC_WRD_LO 2

// timing counts in cpu clock cycles, and words per line
`define ICTC_FWD_CYC 3'h4
`define ICTC_DLV_CYC 3'h3
`define ICTC_LINE_WORDS 3'h4

`endif

/* hdl/ictc_pkg.sv */
package ictc_pkg;
  typedef logic [8:0] ictc_idx_t;
  typedef logic [10:0] ictc_tag_t;
  typedef logic [1:0] ictc_woff_t;
  typedef logic [31:0] ictc_word_t;
  typedef logic [23:0] ictc_addr_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_HIT2  = 5'b00010,
    ST_FWD   = 5'b00100,
    ST_FILL  = 5'b01000,
    ST_INVAL = 5'b10000
  } ictc_state_t;
endpackage : ictc_pkg

/* hdl/ictc_array_if.sv */
interface ictc_array_if;
  import ictc_pkg::*;
  // lookup port
  ictc_idx_t lk_index;
  ictc_woff_t lk_word;
  logic [1:0][10:0] lk_tag;
  logic [1:0] lk_valid;
  logic lk_lru;
  logic [1:0][31:0] lk_data;
  // line fill
  logic fill_we;
  ictc_idx_t fill_index;
  logic fill_way;
  ictc_woff_t fill_word;
  ictc_word_t fill_data;
  // tag write and validation
  logic tag_we;
  ictc_idx_t tag_index;
  logic tag_way;
  ictc_tag_t tag_value;
  // invalidation
  logic inv_we;
  ictc_idx_t inv_index;
  logic [1:0] inv_way_mask;
  logic inv_all;
  // replacement tracking
  logic lru_we;
  ictc_idx_t lru_index;
  logic lru_used_way;
  // emulator read
  ictc_idx_t emu_index;
  logic emu_way;
  ictc_woff_t emu_word;
  ictc_word_t emu_data;

  modport ctrl (
    output lk_index, lk_word, fill_we, fill_index, fill_way, fill_word, fill_data,
    output tag_we, tag_index, tag_way, tag_value, inv_we, inv_index, inv_way_mask, inv_all,
    output lru_we, lru_index, lru_used_way, emu_index, emu_way, emu_word,
    input lk_tag, lk_valid, lk_lru, lk_data, emu_data
  );
  modport tags (
    input lk_index, tag_we, tag_index, tag_way, tag_value, inv_we, inv_index, inv_way_mask, inv_all,
    input lru_we, lru_index, lru_used_way,
    output lk_tag, lk_valid, lk_lru
  );
  modport data (
    input lk_index, lk_word, fill_we, fill_index, fill_way, fill_word, fill_data,
    input emu_index, emu_way, emu_word,
    output lk_data, emu_data
  );
endinterface : ictc_array_if

/* hdl/ictc_tag_store.sv */
module ictc_tag_store
  import ictc_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // array port
  ictc_array_if.tags arr
);
  logic [511:0] valid [2];
  logic [511:0] next_valid [2];
  ictc_tag_t tag_mem [2][512];
  ictc_tag_t next_tag_mem [2][512];
  logic [511:0] lru;
  logic [511:0] next_lru;

  ////////////////////////////////////////////////////////////////////////////////
  // per way tag and valid storage
  for (genvar w = 0; w < 2; w++) begin : g_way
    always_comb begin
      next_valid[w] = valid[w];
      next_tag_mem[w] = tag_mem[w];
      if (arr.inv_all) begin
        next_valid[w] = '0;
      end else begin
        if (arr.inv_we && arr.inv_way_mask[w]) begin
          next_valid[w][arr.inv_index] = 1'b0;
        end
        if (arr.tag_we && (arr.tag_way == 1'(w))) begin
          next_valid[w][arr.tag_index] = 1'b1;
        end
      end
      if (arr.tag_we && (arr.tag_way == 1'(w))) begin
        next_tag_mem[w][arr.tag_index] = arr.tag_value;
      end
    end

    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        valid[w] <= '0;
      end else begin
        valid[w] <= next_valid[w];
      end
      tag_mem[w] <= next_tag_mem[w];
    end

    assign arr.lk_tag[w] = tag_mem[w][arr.lk_index];
    assign arr.lk_valid[w] = valid[w][arr.lk_index];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // least recently used way per set
  always_comb begin
    next_lru = lru;
    if (arr.lru_we) begin
      next_lru[arr.lru_index] = ~arr.lru_used_way;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      lru <= '0;
    end else begin
      lru <= next_lru;
    end
  end

  assign arr.lk_lru = lru[arr.lk_index];
endmodule : ictc_tag_store

/* hdl/ictc_data_store.sv */
module ictc_data_store
  import ictc_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // array port
  ictc_array_if.data arr
);
  ictc_word_t mem [2][512][4];
  ictc_word_t next_mem [2][512][4];

  ////////////////////////////////////////////////////////////////////////////////
  // per way line storage, written one word at a time during a fill
  for (genvar w = 0; w < 2; w++) begin : g_way
    always_comb begin
      next_mem[w] = mem[w];
      if (arr.fill_we && (arr.fill_way == 1'(w))) begin
        next_mem[w][arr.fill_index][arr.fill_word] = arr.fill_data;
      end
    end

    always_ff @(posedge i_ref_clk) begin
      mem[w] <= next_mem[w];
    end

    assign arr.lk_data[w] = mem[w][arr.lk_index][arr.lk_word];
  end

  // read only port, no side effects
  assign arr.emu_data = mem[arr.emu_way][arr.emu_index][arr.emu_word];
endmodule : ictc_data_store

/* hdl/ictc_icache_top.sv */
`include "ictc_regs.svh"

module ictc_icache_top
  import ictc_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // cpu fetch port
  input wire logic i_fetch_req,
  input wire logic [23:0] i_fetch_addr,
  output logic o_fetch_ready,
  output logic o_fetch_valid,
  output logic [31:0] o_fetch_data,
  // external memory port
  output logic o_ext_req,
  output logic [23:0] o_ext_addr,
  output logic o_ext_burst4,
  input wire logic i_ext_rvalid,
  input wire logic [31:0] i_ext_rdata,
  // cpu status
  input wire logic i_cache_on_bit,
  // i/o register port
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [15:0] i_io_wdata,
  output logic [15:0] o_io_rdata,
  // emulation
  input wire logic i_dbg_mode,
  input wire logic i_emu_rd,
  input wire logic [23:0] i_emu_addr,
  input wire logic i_emu_way,
  output logic o_emu_valid,
  output logic [31:0] o_emu_data,
  input wire logic i_bkpt_event,
  input wire logic [23:0] i_bkpt_addr
);
  ictc_array_if arr ();

  ictc_tag_store u_tag_store (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .arr(arr)
  );

  ictc_data_store u_data_store (
    .i_ref_clk(i_ref_clk),
    .arr(arr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // state
  ictc_state_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [2:0] fill_cnt, next_fill_cnt;
  logic fill_full, next_fill_full;
  logic fill_way, next_fill_way;
  logic burst, next_burst;
  ictc_addr_t miss_addr, next_miss_addr;
  logic [2:0] dlv_cnt, next_dlv_cnt;
  logic dlv_wait, next_dlv_wait;
  logic dlv_done, next_dlv_done;
  ictc_word_t hold_data, next_hold_data;
  logic prev_req, next_prev_req;
  ictc_addr_t prev_addr, next_prev_addr;
  logic next_fetch_ready, next_fetch_valid;
  ictc_word_t next_fetch_data;
  logic next_ext_req, next_ext_burst4;
  ictc_addr_t next_ext_addr;
  logic [15:0] gctrl, next_gctrl;
  logic [15:0] far_lo, next_far_lo;
  logic [7:0] far_hi, next_far_hi;
  logic bkpt_pend, next_bkpt_pend;
  ictc_addr_t bkpt_addr, next_bkpt_addr;
  logic [15:0] next_io_rdata;
  logic next_emu_valid;
  ictc_word_t next_emu_data;
  logic flush_done, bkpt_done;
  logic flush_pend;
  logic hit_way;
  logic [1:0] hit_vec;
  logic [1:0] inv_match;
  logic fast;
  ictc_addr_t inv_addr;
  ictc_addr_t line_base;

  assign flush_pend = gctrl[`ICTC_GCTRL_FLUSH_BIT];
  assign inv_addr = bkpt_pend ? bkpt_addr : {far_hi, far_lo};
  assign arr.lk_index = (state == ST_INVAL) ? inv_addr[`ICTC_IDX_HI:`ICTC_IDX_LO]
                                            : i_fetch_addr[`ICTC_IDX_HI:`ICTC_IDX_LO];

  ////////////////////////////////////////////////////////////////////////////////
  // fetch, miss and invalidation sequencing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_fill_cnt = fill_cnt;
    next_fill_full = fill_full;
    next_fill_way = fill_way;
    next_burst = burst;
    next_miss_addr = miss_addr;
    next_dlv_cnt = dlv_cnt;
    next_dlv_wait = dlv_wait;
    next_dlv_done = dlv_done;
    next_hold_data = hold_data;
    next_prev_req = i_fetch_req;
    next_prev_addr = prev_addr;
    next_fetch_valid = 1'b0;
    next_fetch_data = o_fetch_data;
    next_ext_req = 1'b0;
    next_ext_addr = o_ext_addr;
    next_ext_burst4 = o_ext_burst4;
    flush_done = 1'b0;
    bkpt_done = 1'b0;
    line_base = {miss_addr[23:4], 4'h0};
    arr.lk_word = i_fetch_addr[`ICTC_WRD_HI:`ICTC_WRD_LO];
    arr.fill_we = 1'b0;
    arr.fill_index = miss_addr[`ICTC_IDX_HI:`ICTC_IDX_LO];
    arr.fill_way = fill_way;
    arr.fill_word = fill_cnt[1:0];
    arr.fill_data = i_ext_rdata;
    arr.tag_we = 1'b0;
    arr.tag_index = miss_addr[`ICTC_IDX_HI:`ICTC_IDX_LO];
    arr.tag_way = fill_way;
    arr.tag_value = miss_addr[`ICTC_TAG_HI:`ICTC_TAG_LO];
    arr.inv_we = 1'b0;
    arr.inv_index = inv_addr[`ICTC_IDX_HI:`ICTC_IDX_LO];
    arr.inv_way_mask = 2'h0;
    arr.lru_we = 1'b0;
    arr.lru_index = i_fetch_addr[`ICTC_IDX_HI:`ICTC_IDX_LO];
    for (int w = 0; w < 2; w++) begin
      hit_vec[w] = arr.lk_valid[w] && (arr.lk_tag[w] == i_fetch_addr[`ICTC_TAG_HI:`ICTC_TAG_LO]);
      inv_match[w] = arr.lk_valid[w] && (arr.lk_tag[w] == inv_addr[`ICTC_TAG_HI:`ICTC_TAG_LO]);
    end
    hit_way = hit_vec[1];
    arr.lru_used_way = hit_way;
    fast = prev_req && (i_fetch_addr == prev_addr + 24'h4);
    unique case (state)
      ST_IDLE: begin
        if (i_fetch_req && o_fetch_ready) begin
          next_prev_addr = i_fetch_addr;
          next_miss_addr = i_fetch_addr;
          next_cnt = 3'h0;
          if (!i_cache_on_bit) begin
            next_burst = 1'b0;
            next_state = ST_FWD;
          end else if (|hit_vec) begin
            arr.lru_we = 1'b1;
            next_hold_data = arr.lk_data[hit_way];
            if (fast) begin
              next_fetch_valid = 1'b1;
              next_fetch_data = arr.lk_data[hit_way];
            end else begin
              next_state = ST_HIT2;
            end
          end else begin
            next_burst = 1'b1;
            next_fill_way = arr.lk_lru;
            next_state = ST_FWD;
          end
        end else if (bkpt_pend || flush_pend) begin
          next_state = ST_INVAL;
        end
      end
      ST_HIT2: begin
        next_fetch_valid = 1'b1;
        next_fetch_data = hold_data;
        next_state = ST_IDLE;
      end
      ST_FWD: begin
        next_cnt = cnt + 3'h1;
        if (cnt == `ICTC_FWD_CYC - 3'h2) begin
          next_ext_req = 1'b1;
          next_ext_burst4 = burst;
          next_ext_addr = burst ? line_base : miss_addr;
          next_fill_cnt = 3'h0;
          next_fill_full = 1'b0;
          next_dlv_wait = 1'b0;
          next_dlv_done = 1'b0;
          next_state = ST_FILL;
        end
      end
      ST_FILL: begin
        if (dlv_wait) begin
          next_dlv_cnt = dlv_cnt + 3'h1;
          if (dlv_cnt == `ICTC_DLV_CYC - 3'h2) begin
            next_fetch_valid = 1'b1;
            next_fetch_data = hold_data;
            next_dlv_wait = 1'b0;
            next_dlv_done = 1'b1;
          end
        end
        if (i_ext_rvalid && !fill_full) begin
          next_fill_cnt = fill_cnt + 3'h1;
          arr.fill_we = burst;
          if (!burst || (fill_cnt[1:0] == miss_addr[`ICTC_WRD_HI:`ICTC_WRD_LO])) begin
            next_hold_data = i_ext_rdata;
            next_dlv_wait = 1'b1;
            next_dlv_cnt = 3'h0;
          end
          if (!burst || (fill_cnt == `ICTC_LINE_WORDS - 3'h1)) begin
            next_fill_full = 1'b1;
            arr.tag_we = burst;
            arr.lru_we = burst;
            arr.lru_index = miss_addr[`ICTC_IDX_HI:`ICTC_IDX_LO];
            arr.lru_used_way = fill_way;
          end
        end
        if (next_fill_full && next_dlv_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_INVAL: begin
        arr.inv_we = 1'b1;
        if (bkpt_pend) begin
          arr.inv_way_mask = inv_match;
          bkpt_done = 1'b1;
        end else begin
          arr.inv_way_mask = i_cache_on_bit ? inv_match : 2'h0;
          flush_done = 1'b1;
        end
        next_state = ST_IDLE;
      end
    endcase
    next_fetch_ready = (next_state == ST_IDLE) && !bkpt_pend && !flush_pend && !flush_done && !bkpt_done;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      fill_cnt <= 3'h0;
      fill_full <= 1'b0;
      fill_way <= 1'b0;
      burst <= 1'b0;
      miss_addr <= 24'h0;
      dlv_cnt <= 3'h0;
      dlv_wait <= 1'b0;
      dlv_done <= 1'b0;
      hold_data <= 32'h0;
      prev_req <= 1'b0;
      prev_addr <= 24'h0;
      o_fetch_ready <= 1'b0;
      o_fetch_valid <= 1'b0;
      o_fetch_data <= 32'h0;
      o_ext_req <= 1'b0;
      o_ext_addr <= 24'h0;
      o_ext_burst4 <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      fill_cnt <= next_fill_cnt;
      fill_full <= next_fill_full;
      fill_way <= next_fill_way;
      burst <= next_burst;
      miss_addr <= next_miss_addr;
      dlv_cnt <= next_dlv_cnt;
      dlv_wait <= next_dlv_wait;
      dlv_done <= next_dlv_done;
      hold_data <= next_hold_data;
      prev_req <= next_prev_req;
      prev_addr <= next_prev_addr;
      o_fetch_ready <= next_fetch_ready;
      o_fetch_valid <= next_fetch_valid;
      o_fetch_data <= next_fetch_data;
      o_ext_req <= next_ext_req;
      o_ext_addr <= next_ext_addr;
      o_ext_burst4 <= next_ext_burst4;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // i/o registers and breakpoint capture
  always_comb begin
    next_gctrl = gctrl;
    next_far_lo = far_lo;
    next_far_hi = far_hi;
    next_bkpt_pend = bkpt_pend;
    next_bkpt_addr = bkpt_addr;
    next_io_rdata = o_io_rdata;
    arr.inv_all = 1'b0;
    if (flush_done) begin
      next_gctrl[`ICTC_GCTRL_FLUSH_BIT] = 1'b0;
    end
    if (i_io_wr) begin
      unique case (i_io_addr)
        `ICTC_IO_GCTRL: begin
          next_gctrl = i_io_wdata;
          arr.inv_all = !i_io_wdata[`ICTC_GCTRL_FLUSH_BIT];
        end
        `ICTC_IO_FAR_LO: next_far_lo = i_io_wdata;
        `ICTC_IO_FAR_HI: next_far_hi = i_io_wdata[7:0];
        default: ;
      endcase
    end
    if (i_io_rd) begin
      unique case (i_io_addr)
        `ICTC_IO_GCTRL: next_io_rdata = gctrl;
        `ICTC_IO_FAR_LO: next_io_rdata = far_lo;
        `ICTC_IO_FAR_HI: next_io_rdata = {8'h00, far_hi};
        default: next_io_rdata = 16'h0000;
      endcase
    end
    if (bkpt_done) begin
      next_bkpt_pend = 1'b0;
    end
    if (i_bkpt_event && i_dbg_mode) begin
      next_bkpt_pend = 1'b1;
      next_bkpt_addr = i_bkpt_addr;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      gctrl <= `ICTC_GCTRL_RST;
      far_lo <= `ICTC_FAR_RST;
      far_hi <= 8'h00;
      bkpt_pend <= 1'b0;
      bkpt_addr <= 24'h0;
      o_io_rdata <= 16'h0000;
    end else begin
      gctrl <= next_gctrl;
      far_lo <= next_far_lo;
      far_hi <= next_far_hi;
      bkpt_pend <= next_bkpt_pend;
      bkpt_addr <= next_bkpt_addr;
      o_io_rdata <= next_io_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // emulator read, no array writes
  assign arr.emu_index = i_emu_addr[`ICTC_IDX_HI:`ICTC_IDX_LO];
  assign arr.emu_way = i_emu_way;
  assign arr.emu_word = i_emu_addr[`ICTC_WRD_HI:`ICTC_WRD_LO];

  always_comb begin
    next_emu_valid = i_dbg_mode && i_emu_rd;
    next_emu_data = next_emu_valid ? arr.emu_data : o_emu_data;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_emu_valid <= 1'b0;
      o_emu_data <= 32'h0;
    end else begin
      o_emu_valid <= next_emu_valid;
      o_emu_data <= next_emu_data;
    end
  end
endmodule : ictc_icache_top

/* verif/ictc_icache_assertions.sv */
module ictc_icache_assertions (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // fetch port
  input wire logic i_fetch_req,
  input wire logic [23:0] i_fetch_addr,
  input wire logic o_fetch_ready,
  input wire logic o_fetch_valid,
  input wire logic [31:0] o_fetch_data,
  // memory port
  input wire logic o_ext_req,
  input wire logic [23:0] o_ext_addr,
  input wire logic o_ext_burst4,
  input wire logic i_ext_rvalid,
  input wire logic [31:0] i_ext_rdata,
  // register port and emulation
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic [15:0] o_io_rdata,
  input wire logic i_dbg_mode,
  input wire logic i_emu_rd,
  input wire logic o_emu_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_req;
  logic [23:0] last_addr;
  wire tk = i_fetch_req && o_fetch_ready;
  wire fast = prev_req && (i_fetch_addr == last_addr + 24'h4);
  always_ff @(posedge i_ref_clk) begin
    prev_req <= i_sys_rst ? 1'b0 : i_fetch_req;
    last_addr <= i_sys_rst ? 24'h0 : (tk ? i_fetch_addr : last_addr);
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  AST_MISS_FWD: assert property (
    o_ext_req |-> $past(tk, 4)) else $error("memory request not four cycles after fetch");
  AST_EXT_ONCE: assert property (
    o_ext_req |=> !o_ext_req [*4]) else $error("memory request repeated during fill");
  AST_LINE_BASE: assert property (
    o_ext_req && o_ext_burst4 |-> o_ext_addr[3:0] == 4'h0) else $error("line fill not from word 0");
  AST_BYPASS_ADDR: assert property (
    o_ext_req && !o_ext_burst4 |-> o_ext_addr == $past(i_fetch_addr, 4)) else $error("bypass address wrong");
  AST_DIRECT_DLV: assert property (
    o_ext_req && !o_ext_burst4 ##[1:20] i_ext_rvalid |-> ##3 o_fetch_valid && o_fetch_data == $past(i_ext_rdata, 3))
    else $error("word not delivered three cycles after arrival");
  AST_SLOW_GAP: assert property (
    tk && !fast |=> !o_fetch_valid && !o_fetch_ready) else $error("slow request answered early");
  AST_EMU_ANS: assert property (
    i_emu_rd && i_dbg_mode |=> o_emu_valid) else $error("emulator read not answered");
  AST_EMU_ONLY: assert property (
    o_emu_valid |-> $past(i_emu_rd && i_dbg_mode)) else $error("emulator answer without read");
  AST_FAR_HI: assert property (
    i_io_rd && i_io_addr == 16'h0002 |=> o_io_rdata[15:8] == 8'h00) else $error("flush high upper bits set");
  AST_UNMAPPED: assert property (
    i_io_rd && i_io_addr > 16'h0002 |=> o_io_rdata == 16'h0000) else $error("unmapped read not zero");
endmodule : ictc_icache_assertions

bind ictc_icache_top ictc_icache_assertions ictc_icache_assertions_inst (.*);

/* verif/ictc_mem_model.sv */
module ictc_mem_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // latency control
  input wire logic [3:0] i_lat,
  // memory port
  input wire logic i_req,
  input wire logic [23:0] i_addr,
  input wire logic i_burst4,
  output logic o_rvalid,
  output logic [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] cur = 24'h0;
  int wait_cnt = 0;
  int left = 0;
  ////////////////////////////////////////////////////////////
  always @(posedge i_ref_clk) begin
    o_rvalid <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_sys_rst) begin
      left <= 0;
      o_rdata <= 32'h0;
    end else if (i_req) begin
      cur <= i_addr;
      left <= i_burst4 ? 4 : 1;
      wait_cnt <= 32'(i_lat);
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (left > 0) begin
      o_rvalid <= 1'b1;
      o_rdata <= {8'h5a, cur};
      cur <= cur + 24'h4;
      left <= left - 1;
    end
  end
endmodule : ictc_mem_model

/* verif/ictc_icache_top_tb.sv */
module ictc_icache_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk, i_sys_rst = 1'b1, i_fetch_req = 1'b0, i_cache_on_bit = 1'b0, i_io_wr = 1'b0, i_io_rd = 1'b0;
  logic i_dbg_mode = 1'b0, i_emu_rd = 1'b0, i_emu_way = 1'b0, i_bkpt_event = 1'b0, emu_seen = 1'b0;
  logic [23:0] i_fetch_addr = 24'h0, i_emu_addr = 24'h0, i_bkpt_addr = 24'h0, o_ext_addr;
  logic [15:0] i_io_addr = 16'h0, i_io_wdata = 16'h0, o_io_rdata;
  logic [3:0] mem_lat = 4'h0;
  logic o_fetch_ready, o_fetch_valid, o_ext_req, o_ext_burst4, o_emu_valid, i_ext_rvalid;
  logic [31:0] o_fetch_data, i_ext_rdata, o_emu_data;
  int miscompares = 0;
  int check_count = 0;
  int n, k, j, tt[4];
  logic tk_flag;
  logic [23:0] r_addr [6] = '{24'h000008, 24'h000008, 24'h012340, 24'h01234c, 24'h0a0004, 24'h0a0004};
  logic [3:0] r_lat [6] = '{4'h0, 4'h0, 4'h3, 4'h0, 4'h1, 4'h1};
  logic r_on [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  int r_cyc [6] = '{11, 2, 12, 2, 10, 10};
  ictc_icache_top ictc_icache_top_inst (.*);
  ictc_mem_model ictc_mem_model_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_lat(mem_lat),
    .i_req(o_ext_req), .i_addr(o_ext_addr), .i_burst4(o_ext_burst4), .o_rvalid(i_ext_rvalid), .o_rdata(i_ext_rdata));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic guard(input int cnt, input int lim);
    if (cnt >= lim) begin
      miscompares++;
      $display("CHECK FAILED wait expected done seen timeout");
      finish_test();
    end
  endtask : guard
  task automatic io(input logic wr, input logic [15:0] a, input logic [15:0] d);
    i_io_addr = a;
    i_io_wdata = d;
    i_io_wr = wr;
    i_io_rd = !wr;
    @(negedge i_ref_clk);
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
    @(negedge i_ref_clk);
  endtask : io
  task automatic fetch(input logic [23:0] a, input logic [3:0] lat, input logic on, input int cyc);
    int c;
    i_cache_on_bit = on;
    mem_lat = lat;
    i_fetch_addr = a;
    i_fetch_req = 1'b1;
    for (c = 0; o_fetch_ready !== 1'b1; c++) begin
      guard(c, 40);
      @(negedge i_ref_clk);
    end
    @(negedge i_ref_clk);
    i_fetch_req = 1'b0;
    for (c = 1; o_fetch_valid !== 1'b1; c++) begin
      guard(c, 40);
      if (o_ext_req === 1'b1) begin
        chk("ext_addr", 32'(on ? {a[23:4], 4'h0} : a), 32'(o_ext_addr));
        chk("ext_burst4", 32'(on), 32'(o_ext_burst4));
      end
      @(negedge i_ref_clk);
    end
    chk("latency", cyc, c);
    chk("fetch_data", {8'h5a, a}, o_fetch_data);
  endtask : fetch
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    io(1'b0, 16'h0000, 16'h0000);
    chk("ctrl_reset", 32'h0000, 32'(o_io_rdata));
    io(1'b1, 16'h0002, 16'hff01);
    io(1'b0, 16'h0002, 16'h0000);
    chk("far_hi", 32'h0001, 32'(o_io_rdata));
    io(1'b0, 16'h0003, 16'h0000);
    chk("unmapped", 32'h0000, 32'(o_io_rdata));
    io(1'b1, 16'h0000, 16'hce3c);
    io(1'b0, 16'h0000, 16'h0000);
    chk("ctrl_init", 32'hce3c, 32'(o_io_rdata));
    $display("test registers done");
    for (int r = 0; r < 6; r++) begin
      fetch(r_addr[r], r_lat[r], r_on[r], r_cyc[r]);
    end
    $display("test fetch table done");
    @(negedge i_ref_clk);
    i_cache_on_bit = 1'b1;
    i_fetch_addr = 24'h012340;
    i_fetch_req = 1'b1;
    k = 0;
    j = 0;
    tk_flag = 1'b0;
    for (n = 0; j < 4; n++) begin
      guard(n, 40);
      if (o_fetch_valid === 1'b1) begin
        chk("stream_lat", (j == 0) ? 2 : 1, n - tt[j]);
        chk("stream_data", 32'h5a012340 + 32'(4 * j), o_fetch_data);
        j++;
      end
      if (tk_flag) begin
        k++;
        i_fetch_addr = i_fetch_addr + 24'h4;
        i_fetch_req = (k < 4);
      end
      tk_flag = i_fetch_req && (o_fetch_ready === 1'b1);
      if (tk_flag) begin
        tt[k] = n;
      end
      @(negedge i_ref_clk);
    end
    i_fetch_req = 1'b0;
    $display("test stream done");
    io(1'b1, 16'h0001, 16'h0008);
    io(1'b1, 16'h0002, 16'h0000);
    io(1'b1, 16'h0000, 16'hde3c);
    for (n = 0; n < 30; n++) begin
      io(1'b0, 16'h0000, 16'h0000);
      if (o_io_rdata[12] === 1'b0) break;
    end
    guard(n, 30);
    chk("flush_done", 32'hce3c, 32'(o_io_rdata));
    fetch(24'h000008, 4'h0, 1'b1, 11);
    $display("test line flush done");
    i_dbg_mode = 1'b1;
    i_emu_addr = 24'h000008;
    for (n = 0; n < 2; n++) begin
      i_emu_way = n[0];
      i_emu_rd = 1'b1;
      @(negedge i_ref_clk);
      i_emu_rd = 1'b0;
      chk("emu_valid", 32'h1, 32'(o_emu_valid));
      emu_seen = emu_seen | (o_emu_data === 32'h5a000008);
      @(negedge i_ref_clk);
    end
    chk("emu_data", 32'h1, 32'(emu_seen));
    fetch(24'h000008, 4'h0, 1'b1, 2);
    $display("test emulator done");
    i_bkpt_addr = 24'h012344;
    i_bkpt_event = 1'b1;
    @(negedge i_ref_clk);
    i_bkpt_event = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    fetch(24'h012344, 4'h0, 1'b1, 10);
    $display("test breakpoint done");
    i_cache_on_bit = 1'b0;
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    io(1'b0, 16'h0000, 16'h0000);
    chk("ctrl_rerun", 32'h0000, 32'(o_io_rdata));
    io(1'b1, 16'h0000, 16'hce3c);
    fetch(24'h012348, 4'h0, 1'b1, 11);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : ictc_icache_top_tb
